// ==== gpio_pkg.sv ====
// GPIO port package: register map, field layouts, reset values.
// Assumes an AXI4-Lite register bus with 32-bit data.
package gpio_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_VALUE     = 8'h00;
	localparam logic [7:0] ADDR_DIRECTION = 8'h04;
	localparam logic [7:0] ADDR_STYLE     = 8'h08;
	localparam logic [7:0] ADDR_IRQ_OPT   = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
	localparam logic [7:0] ADDR_ANALOG    = 8'h18;

	// ---------------------------------------------------------------
	// Field positions of the interrupt option register
	// ---------------------------------------------------------------
	localparam int IRQ_OPT_LEVEL_BIT = 6;
	localparam int IRQ_OPT_RISE_BIT  = 5;
	localparam int IRQ_OPT_ALLOW_BIT = 4;

	// Widths and reset values
	localparam int          PIN_COUNT  = 8;
	localparam logic [7:0]  PORT_RESET = 8'h00;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Per-pin configuration decoded from direction, style, value
	typedef enum {
		GPIO_IN_PULL,
		GPIO_IN_FLOAT,
		GPIO_IN_IRQ,
		GPIO_IN_ANALOG,
		GPIO_OUT_OPEN,
		GPIO_OUT_PUSH
	} gpio_mode_t;

endpackage : gpio_pkg

// ==== gpio_pin_if.sv ====
// Interface between the port core and one pin slice.
// Assumes a single clock domain; no clocking block.
`timescale 1ns/1ps
interface gpio_pin_if;
	logic cfg_dir;   // Direction bit
	logic cfg_style; // Style bit
	logic cfg_val;   // Value latch bit
	logic pin_sync;  // Synchronised pin level
	logic drv_low;   // N-side drive
	logic drv_high;  // P-side drive
	logic pull_en;   // Pull-up enable
	logic irq_en;    // Pin attached to interrupt logic
	logic analog_en; // Pin routed to converter

	modport core (output cfg_dir, cfg_style, cfg_val,
		input pin_sync, drv_low, drv_high, pull_en, irq_en, analog_en);
	modport slice (input cfg_dir, cfg_style, cfg_val,
		output pin_sync, drv_low, drv_high, pull_en, irq_en, analog_en);
endinterface : gpio_pin_if

// ==== gpio_pin_slice.sv ====
// One pin slice: input synchroniser and mode decode.
// Assumes configuration bits come from core-clock registers.
`timescale 1ns/1ps
module gpio_pin_slice (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	// Raw pin level
	input  wire logic i_pin,
	// Core side
	gpio_pin_if.slice pin
);
	logic sync1_reg;
	logic sync2_reg;
	gpio_pkg::gpio_mode_t mode;

	// Two-flop synchroniser, reset to pulled-up idle: no false edge
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= i_pin;
			sync2_reg <= sync1_reg;
		end
	end
	assign pin.pin_sync = sync2_reg;

	// Mode decode from direction, style and value
	always_comb begin
		if (!pin.cfg_dir && !pin.cfg_style && !pin.cfg_val)
			mode = gpio_pkg::GPIO_IN_PULL;
		else if (!pin.cfg_dir && !pin.cfg_style)
			mode = gpio_pkg::GPIO_IN_FLOAT;
		else if (!pin.cfg_dir && !pin.cfg_val)
			mode = gpio_pkg::GPIO_IN_IRQ;
		else if (!pin.cfg_dir)
			mode = gpio_pkg::GPIO_IN_ANALOG;
		else if (!pin.cfg_style)
			mode = gpio_pkg::GPIO_OUT_OPEN;
		else
			mode = gpio_pkg::GPIO_OUT_PUSH;
	end

	// Output stage: one push-pull stage, P side gated for open drain
	assign pin.drv_low   = pin.cfg_dir && !pin.cfg_val;
	assign pin.drv_high  = (mode == gpio_pkg::GPIO_OUT_PUSH)
		&& pin.cfg_val;
	assign pin.pull_en   = (mode == gpio_pkg::GPIO_IN_PULL)
		|| (mode == gpio_pkg::GPIO_IN_IRQ);
	assign pin.irq_en    = (mode == gpio_pkg::GPIO_IN_IRQ);
	assign pin.analog_en = (mode == gpio_pkg::GPIO_IN_ANALOG);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_sync_delay;
		@(posedge i_clk_sys) disable iff (i_rst)
		##2 (sync2_reg == $past(i_pin, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("pin synchroniser delay wrong");

	property p_open_no_high;
		@(posedge i_clk_sys) disable iff (i_rst)
		(pin.cfg_dir && !pin.cfg_style) |-> !pin.drv_high;
	endproperty
	a_open_no_high: assert property (p_open_no_high)
		else $error("open drain drives high");

	property p_input_no_drive;
		@(posedge i_clk_sys) disable iff (i_rst)
		!pin.cfg_dir |-> !(pin.drv_low || pin.drv_high);
	endproperty
	a_input_no_drive: assert property (p_input_no_drive)
		else $error("input pin is driven");
endmodule : gpio_pin_slice

// ==== gpio_port.sv ====
// Eight-pin general-purpose port with AXI4-Lite register access.
// Assumes one core clock and an async active-high reset.
//
// What this block does
// - Reset clears all port registers: pull-up input, no interrupt.
// - Bit n of each register except interrupt option controls only pin n.
// - Direction 0 means input; value reads return live pin level.
// - Direction 1 means output; value reads return the latch.
// - Input, style 0: value 0 pull-up, value 1 floating; no interrupt.
// - Input, style 1, value 0: pull-up plus interrupt attachment.
// - Input, style 1, value 1: analog input routed to converter.
// - Output, style 0: open drain, 0 pulls low, 1 floats.
// - Output, style 1: push-pull, drives value level.
// - Open drain is push-pull stage with high side disabled.
// - Each input attachable to interrupts; trigger chosen per port.
// - Pin requests only while global interrupt allow bit is set.
`timescale 1ns/1ps
module gpio_port (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	// AXI4-Lite write response
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Port pins
	input  wire logic [7:0]  i_pin,
	output logic [7:0]       o_pin,
	output logic [7:0]       o_pin_oe,
	output logic [7:0]       o_pull_en,
	// Converter routing and interrupts
	output logic [7:0]       o_analog_sel,
	output logic [7:0]       o_pin_irq,
	output logic             o_irq
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0]  value_reg;     // pin_value_bits latch
	logic [7:0]  direction_reg; // pin_direction_bits
	logic [7:0]  style_reg;     // pin_style_bits
	logic [7:0]  irq_opt_reg;   // irq_option_reg
	logic [7:0]  irq_stat_reg;
	logic [7:0]  irq_mask_reg;
	logic [7:0]  pin_prev_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        aw_have_reg;
	logic        w_have_reg;

	logic [7:0]  pin_sync;
	logic [7:0]  drv_low;
	logic [7:0]  drv_high;
	logic [7:0]  pull_en;
	logic [7:0]  irq_en;
	logic [7:0]  analog_en;
	logic [7:0]  trig;
	logic [7:0]  value_rd;
	logic [7:0]  rd_byte;
	logic        rd_ok;
	logic        wr_fire;
	logic        wr_ok;
	logic        rd_fire;
	logic        stat_rd;
	logic        global_irq_allow;
	logic        wr_lane0;
	logic        irq_any;

	// ---------------------------------------------------------------
	// Pin slices
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < gpio_pkg::PIN_COUNT; g++) begin : g_pin
			gpio_pin_if pif ();
			// Bit g of each register feeds pin g only
			assign pif.cfg_dir   = direction_reg[g];
			assign pif.cfg_style = style_reg[g];
			assign pif.cfg_val   = value_reg[g];
			assign pin_sync[g]   = pif.pin_sync;
			assign drv_low[g]    = pif.drv_low;
			assign drv_high[g]   = pif.drv_high;
			assign pull_en[g]    = pif.pull_en;
			assign irq_en[g]     = pif.irq_en;
			assign analog_en[g]  = pif.analog_en;
			gpio_pin_slice u_slice (
				.i_clk_sys (i_clk_sys),
				.i_rst     (i_rst),
				.i_pin     (i_pin[g]),
				.pin       (pif.slice)
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Bus handshake
	// ---------------------------------------------------------------
	assign wr_fire  = aw_have_reg && w_have_reg && !o_bvalid;
	assign rd_fire  = i_arvalid && o_arready;
	assign wr_lane0 = w_strb_reg[0];
	assign wr_ok    = (aw_addr_reg == gpio_pkg::ADDR_VALUE)
		|| (aw_addr_reg == gpio_pkg::ADDR_DIRECTION)
		|| (aw_addr_reg == gpio_pkg::ADDR_STYLE)
		|| (aw_addr_reg == gpio_pkg::ADDR_IRQ_OPT)
		|| (aw_addr_reg == gpio_pkg::ADDR_IRQ_STAT)
		|| (aw_addr_reg == gpio_pkg::ADDR_IRQ_MASK)
		|| (aw_addr_reg == gpio_pkg::ADDR_ANALOG);

	// Write address and data capture, in either order
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_awready   <= 1'b1;
			o_wready    <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_addr_reg <= i_awaddr;
				aw_have_reg <= 1'b1;
				o_awready   <= 1'b0;
			end else if (wr_fire) begin
				aw_have_reg <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_data_reg <= i_wdata;
				w_strb_reg <= i_wstrb;
				w_have_reg <= 1'b1;
				o_wready   <= 1'b0;
			end else if (wr_fire) begin
				w_have_reg <= 1'b0;
			end
			if (o_bvalid && i_bready) begin
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	// Write response
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= gpio_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			o_bvalid <= 1'b1;
			o_bresp  <= wr_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			value_reg     <= gpio_pkg::PORT_RESET;
			direction_reg <= gpio_pkg::PORT_RESET;
			style_reg     <= gpio_pkg::PORT_RESET;
			irq_opt_reg   <= gpio_pkg::PORT_RESET;
			irq_mask_reg  <= gpio_pkg::PORT_RESET;
		end else if (wr_fire && wr_lane0) begin
			if (aw_addr_reg == gpio_pkg::ADDR_VALUE)
				value_reg <= w_data_reg[7:0];
			else if (aw_addr_reg == gpio_pkg::ADDR_DIRECTION)
				direction_reg <= w_data_reg[7:0];
			else if (aw_addr_reg == gpio_pkg::ADDR_STYLE)
				style_reg <= w_data_reg[7:0];
			else if (aw_addr_reg == gpio_pkg::ADDR_IRQ_OPT)
				irq_opt_reg <= w_data_reg[7:0] & 8'h70;
			else if (aw_addr_reg == gpio_pkg::ADDR_IRQ_MASK)
				irq_mask_reg <= w_data_reg[7:0];
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Inputs read the live level, outputs the latch
	assign value_rd = (direction_reg & value_reg)
		| (~direction_reg & pin_sync);

	// Read data select
	always_comb begin
		rd_ok   = 1'b1;
		rd_byte = 8'h00;
		if (i_araddr == gpio_pkg::ADDR_VALUE)
			rd_byte = value_rd;
		else if (i_araddr == gpio_pkg::ADDR_DIRECTION)
			rd_byte = direction_reg;
		else if (i_araddr == gpio_pkg::ADDR_STYLE)
			rd_byte = style_reg;
		else if (i_araddr == gpio_pkg::ADDR_IRQ_OPT)
			rd_byte = irq_opt_reg;
		else if (i_araddr == gpio_pkg::ADDR_IRQ_STAT)
			rd_byte = irq_stat_reg;
		else if (i_araddr == gpio_pkg::ADDR_IRQ_MASK)
			rd_byte = irq_mask_reg;
		else if (i_araddr == gpio_pkg::ADDR_ANALOG)
			rd_byte = analog_en;
		else
			rd_ok = 1'b0;
	end
	assign stat_rd = rd_fire && (i_araddr == gpio_pkg::ADDR_IRQ_STAT);

	// Read channel, one outstanding read
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= gpio_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rdata   <= {24'h000000, rd_byte};
			o_rresp   <= rd_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt detection
	// ---------------------------------------------------------------
	assign global_irq_allow = irq_opt_reg[gpio_pkg::IRQ_OPT_ALLOW_BIT];
	assign irq_any          = |(irq_stat_reg & irq_mask_reg);

	// Previous synchronised level for edge detection
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			pin_prev_reg <= 8'hff;
		else
			pin_prev_reg <= pin_sync;
	end

	// Per-port trigger: low level, rising or falling edge
	always_comb begin
		if (irq_opt_reg[gpio_pkg::IRQ_OPT_LEVEL_BIT])
			trig = ~pin_sync;
		else if (irq_opt_reg[gpio_pkg::IRQ_OPT_RISE_BIT])
			trig = pin_sync & ~pin_prev_reg;
		else
			trig = ~pin_sync & pin_prev_reg;
	end

	// Sticky status, cleared by read; a new event wins
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			irq_stat_reg <= 8'h00;
		else
			irq_stat_reg <= (stat_rd ? 8'h00 : irq_stat_reg)
				| (trig & irq_en & {8{global_irq_allow}});
	end

	// ---------------------------------------------------------------
	// Pin outputs, all registered
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_pin        <= 8'h00;
			o_pin_oe     <= 8'h00;
			o_pull_en    <= 8'hff;
			o_analog_sel <= 8'h00;
			o_pin_irq    <= 8'h00;
			o_irq        <= 1'b0;
		end else begin
			o_pin        <= drv_high;
			o_pin_oe     <= drv_low | drv_high;
			o_pull_en    <= pull_en;
			o_analog_sel <= analog_en;
			o_pin_irq    <= trig & irq_en & {8{global_irq_allow}};
			o_irq        <= irq_any;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_no_irq_when_blocked;
		@(posedge i_clk_sys) disable iff (i_rst)
		!global_irq_allow |=> (o_pin_irq == 8'h00);
	endproperty
	a_no_irq_when_blocked: assert property (p_no_irq_when_blocked)
		else $error("pin request while global allow clear");

	property p_read_input_live;
		@(posedge i_clk_sys) disable iff (i_rst)
		(rd_fire && i_araddr == gpio_pkg::ADDR_VALUE)
		|=> (o_rdata[7:0] == $past(value_rd));
	endproperty
	a_read_input_live: assert property (p_read_input_live)
		else $error("value read mismatch");

	property p_out_latch;
		@(posedge i_clk_sys) disable iff (i_rst)
		(direction_reg[0] && style_reg[0]) ##1 (direction_reg[0]
			&& style_reg[0] && $stable(value_reg[0]))
		|-> (o_pin[0] == value_reg[0] && o_pin_oe[0]);
	endproperty
	a_out_latch: assert property (p_out_latch)
		else $error("push-pull pin not following latch");

	property p_open_drain;
		@(posedge i_clk_sys) disable iff (i_rst)
		(direction_reg[1] && !style_reg[1]) |=> (o_pin[1] == 1'b0
			&& o_pin_oe[1] == !$past(value_reg[1]));
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open drain behaviour wrong");

	property p_irq_level;
		@(posedge i_clk_sys) disable iff (i_rst)
		##1 (o_irq == $past(irq_any));
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt output wrong");

	property p_analog_route;
		@(posedge i_clk_sys) disable iff (i_rst)
		(!direction_reg[2] && style_reg[2] && value_reg[2])
		|=> o_analog_sel[2] && !o_pull_en[2];
	endproperty
	a_analog_route: assert property (p_analog_route)
		else $error("analog routing wrong");

	property p_reset_state;
		@(posedge i_clk_sys)
		$fell(i_rst) |-> (direction_reg == 8'h00 && o_pull_en == 8'hff);
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");

	property p_no_irq_detach;
		@(posedge i_clk_sys) disable iff (i_rst)
		(!style_reg[3] || direction_reg[3]) |=> !o_pin_irq[3];
	endproperty
	a_no_irq_detach: assert property (p_no_irq_detach)
		else $error("request from detached pin");

	c_write: cover property (@(posedge i_clk_sys) o_bvalid && i_bready);
	c_read: cover property (@(posedge i_clk_sys) o_rvalid && i_rready);
	c_irq: cover property (@(posedge i_clk_sys) $rose(o_irq));
	c_stat_clear: cover property (@(posedge i_clk_sys) stat_rd
		&& irq_stat_reg != 8'h00);
endmodule : gpio_port

// ==== gpio_board_model.sv ====
// Board model: resolves each port pin from chip drive, board drive, pull-up.
// Assumes the bench sets board drive only on pins the chip does not drive.
`timescale 1ns/1ps
module gpio_board_model (
	// Clock
	input  wire logic       i_clk_sys,
	// Chip side
	input  wire logic [7:0] i_pin_out,
	input  wire logic [7:0] i_pin_oe,
	input  wire logic [7:0] i_pull_en,
	// Board side
	input  wire logic [7:0] i_board_en,
	input  wire logic [7:0] i_board_val,
	output logic [7:0]      o_level
);
	logic [7:0] float_q = 8'h00;

	// Undriven pin without pull-up flips every cycle
	always @(posedge i_clk_sys) begin
		float_q <= ~o_level;
	end

	// Chip drive wins, then board, then pull-up, then floating pattern
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_pin_oe[i])
				o_level[i] = i_pin_out[i];
			else if (i_board_en[i])
				o_level[i] = i_board_val[i];
			else if (i_pull_en[i])
				o_level[i] = 1'b1;
			else
				o_level[i] = float_q[i];
		end
	end
endmodule : gpio_board_model

// ==== gpio_port_test.sv ====
// Self-checking bench for the eight-pin port, random and corner cases.
// Assumes gpio_pkg, gpio_port and gpio_board_model are compiled first.
`timescale 1ns/1ps
module gpio_port_test;
	logic        clk = 0, rst = 1;
	logic [7:0]  awaddr = 0, araddr = 0, pin_out, pin_oe, pull_en, ana;
	logic [7:0]  pin_irq, level, brd_en = 0, brd_val = 0;
	logic [31:0] wdata = 0, rdata, seed = 32'h0a75, rd_v;
	logic [3:0]  wstrb = 4'hf;
	// Response readies stay high: every answer is taken as it appears
	logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, resp;
	logic [7:0]  dir, sty, val, a, k;
	int          failures = 0, check_count = 0;

	// ---------------------------------------------------------------
	// Clock, design and board
	// ---------------------------------------------------------------
	always #5 clk = ~clk;

	gpio_port dut_u (.i_clk_sys(clk), .i_rst(rst), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_pin(level), .o_pin(pin_out), .o_pin_oe(pin_oe),
		.o_pull_en(pull_en), .o_analog_sel(ana), .o_pin_irq(pin_irq),
		.o_irq(irq));

	gpio_board_model board_u (.i_clk_sys(clk), .i_pin_out(pin_out),
		.i_pin_oe(pin_oe), .i_pull_en(pull_en), .i_board_en(brd_en),
		.i_board_val(brd_val), .o_level(level));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	// Pin outputs expected from one config: analog, pull, oe, level
	function automatic logic [31:0] exp_outs(input logic [7:0] d, s, v);
		return {ana_of(d, s, v), ~d & ~v, d & (s | ~v), d & s & v};
	endfunction : exp_outs

	function automatic logic [7:0] ana_of(input logic [7:0] d, s, v);
		return ~d & s & v;
	endfunction : ana_of

	task automatic check(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Bus write; each channel released after its own handshake
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		int n;
		logic ha, hw, hb;
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		n = 0;
		hb = 0;
		while (!hb && n < 100) begin
			@(negedge clk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ha) awvalid <= 0;
			if (hw) wvalid <= 0;
			n++;
		end
		if (!hb) failures++;
	endtask : wr

	// Bus read; data taken at the edge where rvalid is seen
	task automatic rd(input logic [7:0] ad);
		int n;
		logic ha, hr;
		araddr <= ad;
		arvalid <= 1;
		n = 0;
		hr = 0;
		while (!hr && n < 100) begin
			@(negedge clk);
			ha = arvalid & arready;
			hr = rvalid;
			rd_v = rdata;
			resp = rresp;
			@(posedge clk);
			if (ha) arvalid <= 0;
			n++;
		end
		if (!hr) failures++;
	endtask : rd

	// Falls then rises all pins, checks pin request while low
	task automatic pulse_and_read(input logic [7:0] req);
		brd_val <= 8'h00;
		tick(4);
		check("pin_irq", pin_irq, req);
		brd_val <= 8'hff;
		tick(6);
	endtask : pulse_and_read

	task print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// Watchdog
	initial begin
		tick(20000);
		failures++;
		print_verdict();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		tick(5);
		rst <= 0;
		tick(4);
		check("outs", {ana, pull_en, pin_oe, irq},
			{8'h00, 8'hff, 8'h00, 1'b0});
		rd(gpio_pkg::ADDR_VALUE);
		check("value", rd_v, 32'hff);
		rd(gpio_pkg::ADDR_DIRECTION);
		check("dir", rd_v, 32'h0);
		rd(gpio_pkg::ADDR_STYLE);
		check("style", rd_v, 32'h0);
		wstrb <= 4'h0;
		wr(gpio_pkg::ADDR_DIRECTION, 32'hff);
		wstrb <= 4'hf;
		rd(gpio_pkg::ADDR_DIRECTION);
		check("strb0", rd_v, 32'h0);
		wr(8'h1c, 32'h1);
		check("bresp", resp, gpio_pkg::RESP_SLVERR);
		rd(8'h1c);
		check("rresp", resp, gpio_pkg::RESP_SLVERR);
		$display("test reset and map done");
		// Random configurations, one analog pin at most
		for (int t = 0; t < 24; t++) begin
			seed = xs(seed);
			dir = seed[7:0];
			sty = seed[15:8];
			val = seed[23:16];
			a = ana_of(dir, sty, val);
			val = val & ~(a & ~(a & -a));
			brd_en <= ~dir;
			brd_val <= seed[31:24];
			wr(gpio_pkg::ADDR_DIRECTION, {24'h0, dir});
			wr(gpio_pkg::ADDR_STYLE, {24'h0, sty});
			wr(gpio_pkg::ADDR_VALUE, {24'h0, val});
			tick(4);
			check("outs", {ana, pull_en, pin_oe, pin_out},
				exp_outs(dir, sty, val));
			rd(gpio_pkg::ADDR_VALUE);
			check("value", rd_v, {24'h0, (dir & val) | (~dir & seed[31:24])});
			rd(gpio_pkg::ADDR_ANALOG);
			check("analog", rd_v, {24'h0, ana_of(dir, sty, val)});
		end
		$display("test random modes done");
		// One pin attached to interrupts, each trigger mode
		seed = xs(seed);
		k = 8'h01 << seed[2:0];
		brd_en <= 8'hff;
		brd_val <= 8'hff;
		wr(gpio_pkg::ADDR_DIRECTION, 32'h0);
		wr(gpio_pkg::ADDR_VALUE, 32'h0);
		wr(gpio_pkg::ADDR_STYLE, {24'h0, k});
		wr(gpio_pkg::ADDR_IRQ_MASK, {24'h0, k});
		for (int m = 0; m < 3; m++) begin
			// Global allow on, plus falling, rising or low-level trigger
			wr(gpio_pkg::ADDR_IRQ_OPT, 32'h10 | (32'h10 << m));
			rd(gpio_pkg::ADDR_IRQ_STAT);
			pulse_and_read((m == 1) ? 8'h00 : k);
			check("irq", irq, 1'b1);
			rd(gpio_pkg::ADDR_IRQ_STAT);
			check("status", rd_v, {24'h0, k});
			tick(2);
			check("irq_clr", irq, 1'b0);
		end
		wr(gpio_pkg::ADDR_IRQ_MASK, 32'h0);
		pulse_and_read(k);
		check("masked", irq, 1'b0);
		rd(gpio_pkg::ADDR_IRQ_STAT);
		check("status", rd_v, {24'h0, k});
		wr(gpio_pkg::ADDR_IRQ_OPT, 32'h0);
		pulse_and_read(8'h00);
		rd(gpio_pkg::ADDR_IRQ_STAT);
		check("no_allow", rd_v, 32'h0);
		wr(gpio_pkg::ADDR_IRQ_OPT, 32'h10);
		wr(gpio_pkg::ADDR_STYLE, 32'h0);
		pulse_and_read(8'h00);
		rd(gpio_pkg::ADDR_IRQ_STAT);
		check("no_attach", rd_v, 32'h0);
		$display("test interrupts done");
		print_verdict();
	end
endmodule : gpio_port_test
